// ### eib_pkg.sv
// constants and types for the external bus idle insertion block
package eib_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned AREA_W = 3;
    localparam int unsigned CNT_W = 3;
    // register offsets (byte addresses)
    localparam logic [11:0] IDLE_CTRL_OFS = 12'h000;
    localparam logic [11:0] IDLE_STAT_OFS = 12'h004;
    localparam logic [11:0] ADDR_MASK = 12'hFFC;
    // reset value of the control register
    localparam logic [15:0] IDLE_CTRL_RST = 16'hFF00;
    // field positions
    localparam int unsigned COND3_BIT = 15;
    localparam int unsigned COND2_BIT = 14;
    localparam int unsigned COND1_BIT = 13;
    localparam int unsigned COND0_BIT = 12;
    localparam int unsigned CNT_B_LSB = 10;
    localparam int unsigned CNT_A_LSB = 8;
    localparam int unsigned SEL_LSB = 0;
    // status field positions
    localparam int unsigned STAT_CNT_LSB = 0;
    localparam int unsigned STAT_BUSY_BIT = 4;
    localparam int unsigned STAT_AREA_LSB = 8;
    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CYCLE = 3'b010,
        ST_GAP = 3'b100
    } eib_state_t;
endpackage

// ### eib_ahb_regs.sv
// ahb-lite slave holding the idle insertion control register
`timescale 1ns/1ps
module eib_ahb_regs
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic [15:0] status_i,
    output logic [15:0] ctrl_o
);
    import eib_pkg::*;
    logic wr_pend_ff;
    logic [11:0] wr_addr_ff;
    logic addr_phase;
    logic [15:0] rd_word;

    assign addr_phase = hsel_i && hready_i && htrans_i[1];

    always_comb begin
        rd_word = 16'h0000;
        unique case (haddr_i[11:0] & ADDR_MASK)
            IDLE_CTRL_OFS: rd_word = ctrl_o;
            IDLE_STAT_OFS: rd_word = status_i;
            default: rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 12'h000;
        end else begin
            wr_pend_ff <= addr_phase && hwrite_i;
            if (addr_phase) begin
                wr_addr_ff <= haddr_i[11:0] & ADDR_MASK;
            end
        end
    end

    // read data registered at the end of the address phase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hrdata_o <= 32'h00000000;
        end else if (addr_phase && !hwrite_i) begin
            hrdata_o <= {16'h0000, rd_word};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_o <= IDLE_CTRL_RST;
        end else if (wr_pend_ff && wr_addr_ff == IDLE_CTRL_OFS) begin
            ctrl_o <= hwdata_i[15:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hreadyout_o <= 1'b0;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end
endmodule

// ### eib_idle_insert.sv
// idle state insertion between consecutive external bus cycles
//
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
// Function
// - with the dma-write condition on, idles go between a dma single-address write and the next access.
// - with the write-then-read condition on, idles go between a write and a following read.
// - with the area-change condition on, idles go between two reads of different areas.
// - with the read-then-write condition on, idles go between a read and a following write.
// - count field a codes 00 to 11 give one to four idle states.
// - count field a sets the idle count for conditions three and two, and for one and zero unless field b is selected.
// - count field b code 00 gives no idle state and 01 gives two, for conditions one and zero only.
// - a per-area select bit picks field a (0) or field b (1) for conditions one and zero.
module eib_idle_insert
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic cyc_req_i,
    input wire logic cyc_write_i,
    input wire logic cyc_dma_sa_i,
    input wire logic [eib_pkg::AREA_W-1:0] cyc_area_i,
    input wire logic cyc_done_i,
    output logic cyc_start_o,
    output logic bus_idle_o,
    output logic cyc_active_o
);
    import eib_pkg::*;

    eib_state_t state_ff;
    eib_state_t nxt_state;
    logic [15:0] ctrl;
    logic prev_valid_ff;
    logic prev_write_ff;
    logic prev_dma_ff;
    logic [AREA_W-1:0] prev_area_ff;
    logic [CNT_W-1:0] gap_cnt_ff;
    logic [CNT_W-1:0] need_cnt;
    logic [CNT_W-1:0] cnt_a;
    logic [CNT_W-1:0] cnt_b;
    logic [CNT_W-1:0] cnt_sel;
    logic hit3;
    logic hit2;
    logic hit1;
    logic hit0;
    logic [15:0] status;
    logic grant;
    logic gap_load;

    // count field a: codes map to one to four idle states
    function automatic logic [CNT_W-1:0] dec_a(input logic [1:0] code);
        dec_a = {1'b0, code} + 3'h1;
    endfunction

    // count field b: 00 none, 01 two, 10 three, 11 four
    function automatic logic [CNT_W-1:0] dec_b(input logic [1:0] code);
        logic [CNT_W-1:0] v;
        v = 3'h0;
        unique case (code)
            2'h0: v = 3'h0;
            2'h1: v = 3'h2;
            2'h2: v = 3'h3;
            2'h3: v = 3'h4;
        endcase
        dec_b = v;
    endfunction

    // register slave holding the control word; status is read back through it
    eib_ahb_regs u_regs (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hsize_i(hsize_i),
        .hwdata_i(hwdata_i),
        .hready_i(hready_i),
        .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o),
        .status_i(status),
        .ctrl_o(ctrl)
    );

    // idle counts decoded from both count fields
    assign cnt_a = dec_a(ctrl[CNT_A_LSB +: 2]);
    assign cnt_b = dec_b(ctrl[CNT_B_LSB +: 2]);
    assign cnt_sel = ctrl[SEL_LSB + prev_area_ff] ? cnt_b : cnt_a;

    // which enabled conditions the pending cycle meets after the previous one
    assign hit3 = ctrl[COND3_BIT] && prev_dma_ff;
    // a dma single-address write is a write cycle on the bus as well
    assign hit2 = ctrl[COND2_BIT] && prev_write_ff && !cyc_write_i;
    assign hit1 = ctrl[COND1_BIT] && !prev_write_ff && !cyc_write_i
                  && (prev_area_ff != cyc_area_i);
    assign hit0 = ctrl[COND0_BIT] && !prev_write_ff && cyc_write_i;

    // largest demanded gap wins when several conditions meet
    always_comb begin
        need_cnt = 3'h0;
        if (prev_valid_ff) begin
            if (hit3 || hit2) begin
                need_cnt = cnt_a;
            end
            if ((hit1 || hit0) && cnt_sel > need_cnt) begin
                need_cnt = cnt_sel;
            end
        end
    end

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                // a request with no idle demand goes straight to the cycle
                if (cyc_req_i) begin
                    nxt_state = (need_cnt != 3'h0) ? ST_GAP : ST_CYCLE;
                end
            end
            ST_GAP: begin
                // leave on the last idle state so the grant follows at once
                if (gap_cnt_ff == 3'h1) begin
                    nxt_state = ST_CYCLE;
                end
            end
            ST_CYCLE: begin
                if (cyc_done_i) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // the pending cycle is granted on the edge that enters the cycle state
    assign grant = (nxt_state == ST_CYCLE) && (state_ff != ST_CYCLE);
    assign gap_load = (state_ff == ST_IDLE) && cyc_req_i;

    // idle state counter loaded when the gap opens
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap_cnt_ff <= 3'h0;
        end else if (gap_load) begin
            gap_cnt_ff <= need_cnt;
        end else if (state_ff == ST_GAP && gap_cnt_ff != 3'h0) begin
            gap_cnt_ff <= gap_cnt_ff - 3'h1;
        end
    end

    // a previous cycle exists once the first grant has gone out
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_valid_ff <= 1'b0;
        end else if (grant) begin
            prev_valid_ff <= 1'b1;
        end
    end

    // direction of the cycle just granted, kept for the next gap decision
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_write_ff <= 1'b0;
            prev_dma_ff <= 1'b0;
        end else if (grant) begin
            prev_write_ff <= cyc_write_i;
            prev_dma_ff <= cyc_dma_sa_i && cyc_write_i;
        end
    end

    // area of the cycle just granted picks the count select bit later
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_area_ff <= '0;
        end else if (grant) begin
            prev_area_ff <= cyc_area_i;
        end
    end

    // one-cycle grant pulse towards the external bus sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cyc_start_o <= 1'b0;
        end else begin
            cyc_start_o <= grant;
        end
    end

    // high for exactly the inserted idle states
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_idle_o <= 1'b0;
        end else begin
            bus_idle_o <= (nxt_state == ST_GAP);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cyc_active_o <= 1'b0;
        end else begin
            cyc_active_o <= (nxt_state == ST_CYCLE);
        end
    end

    assign status = {5'h00, prev_area_ff, 3'h0, state_ff == ST_GAP, 1'b0, gap_cnt_ff};
endmodule

// ### eib_idle_insert_checker.sv
// port checker for the idle insertion block
`timescale 1ns/1ps
module eib_idle_insert_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic cyc_req_i,
    input wire logic cyc_done_i,
    input wire logic cyc_start_o,
    input wire logic bus_idle_o,
    input wire logic cyc_active_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_gap_end;
        $fell(bus_idle_o) ##0 cyc_start_o;
    endsequence
    AST_HRESP_OKAY: assert property (!hresp_o) else $error("bad response");
    AST_READY_UP: assert property (!$past(rst_i) |-> hreadyout_o) else $error("wait state");
    AST_GAP_BOUND: assert property ($rose(bus_idle_o) |-> ##[1:4] !bus_idle_o)
        else $error("gap over four");
    AST_GAP_THEN_START: assert property ($fell(bus_idle_o) |-> s_gap_end)
        else $error("no grant after gap");
    AST_GAP_CAUSE: assert property ($rose(bus_idle_o) |-> $past(cyc_req_i))
        else $error("gap without request");
    AST_START_PULSE: assert property (cyc_start_o |=> !cyc_start_o) else $error("long grant");
    AST_IDLE_QUIET: assert property (bus_idle_o |-> !cyc_active_o)
        else $error("idle during cycle");
    AST_DONE_ENDS: assert property (cyc_done_i |=> !cyc_active_o) else $error("cycle stuck");
endmodule
bind eib_idle_insert eib_idle_insert_checker eib_idle_insert_checker_inst (.clk_i(clk_i),
    .rst_i(rst_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .cyc_req_i(cyc_req_i),
    .cyc_done_i(cyc_done_i), .cyc_start_o(cyc_start_o), .bus_idle_o(bus_idle_o),
    .cyc_active_o(cyc_active_o));

// ### eib_far_end.sv
// far side model: for lat_i above 0, ends each external cycle lat_i + 1 cycles after its grant
`timescale 1ns/1ps
module eib_far_end (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] lat_i,
    input wire logic cyc_start_i,
    output logic cyc_done_o
);
    logic [3:0] cnt_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= 4'h0;
            cyc_done_o <= 1'b0;
        end else if (cyc_start_i) begin
            cnt_ff <= lat_i;
            cyc_done_o <= 1'b0;
        end else begin
            cyc_done_o <= (cnt_ff == 4'h1);
            if (cnt_ff != 4'h0) begin
                cnt_ff <= cnt_ff - 4'h1;
            end
        end
    end
endmodule

// ### eib_idle_insert_test.sv
// self-checking bench for the idle insertion block
`timescale 1ns/1ps
module eib_idle_insert_test;
    import eib_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hsel_i = 1'b0, hwrite_i = 1'b0, cyc_req_i = 1'b0, cyc_write_i = 1'b0;
    logic cyc_dma_sa_i = 1'b0;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
    logic [1:0] htrans_i = 2'h0;
    logic [2:0] cyc_area_i = 3'h0;
    logic [3:0] lat_i = 4'h3;
    logic hreadyout_o, hresp_o, cyc_done_i, cyc_start_o, bus_idle_o, cyc_active_o;
    int err_total = 0, checks = 0, cyc_n = 0;
    always #2 clk_i = ~clk_i;
    eib_idle_insert eib_idle_insert_inst (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(HSIZE_WORD),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .cyc_req_i(cyc_req_i),
        .cyc_write_i(cyc_write_i), .cyc_dma_sa_i(cyc_dma_sa_i), .cyc_area_i(cyc_area_i),
        .cyc_done_i(cyc_done_i), .cyc_start_o(cyc_start_o), .bus_idle_o(bus_idle_o),
        .cyc_active_o(cyc_active_o));
    eib_far_end eib_far_end_inst (.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat_i),
        .cyc_start_i(cyc_start_o), .cyc_done_o(cyc_done_i));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel_i <= 1'b1;
        haddr_i <= a;
        hwrite_i <= wr;
        htrans_i <= HTRANS_NONSEQ;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask
    // one external cycle {write, dma, area}; n counts idle states before its grant
    task automatic cyc(input logic [4:0] c, output int n);
        n = 0;
        cyc_req_i <= 1'b1;
        {cyc_write_i, cyc_dma_sa_i, cyc_area_i} <= c;
        do begin
            @(posedge clk_i);
            n += int'(bus_idle_o === 1'b1);
        end while (cyc_start_o !== 1'b1);
        cyc_req_i <= 1'b0;
        do @(posedge clk_i); while (cyc_active_o !== 1'b0);
    endtask
    task automatic pair(input logic [15:0] ctrl, input logic [4:0] p, input logic [4:0] q,
        input int exp);
        logic [31:0] rd;
        int n;
        ahb(1'b1, 32'h0, {16'h0, ctrl}, rd);
        cyc(p, n);
        cyc(q, n);
        compare(n, exp);
    endtask
    task automatic test_regs();
        logic [31:0] rd;
        ahb(1'b0, 32'h0, 32'h0, rd);
        compare(rd, 32'h0000_FF00);
        ahb(1'b1, 32'h0, 32'hFFFF_5A3C, rd);
        ahb(1'b0, 32'h0, 32'h0, rd);
        compare(rd, 32'h0000_5A3C);
        ahb(1'b0, 32'h8, 32'h0, rd);
        compare(rd, 32'h0);
        $display("test_regs done");
    endtask
    task automatic test_conditions();
        pair(16'h8100, 5'h18, 5'h10, 2);
        pair(16'h0100, 5'h18, 5'h10, 0);
        pair(16'h4100, 5'h10, 5'h00, 2);
        pair(16'hB100, 5'h10, 5'h00, 0);
        pair(16'h4100, 5'h18, 5'h00, 2);
        pair(16'h2100, 5'h01, 5'h02, 2);
        pair(16'h2100, 5'h01, 5'h01, 0);
        pair(16'h1100, 5'h01, 5'h10, 2);
        pair(16'hE100, 5'h01, 5'h10, 0);
        $display("test_conditions done");
    endtask
    task automatic test_counts();
        logic [31:0] rd;
        lat_i <= 4'h1;
        for (int k = 0; k < 4; k++) begin
            pair(16'h4000 | 16'(k << 8), 5'h10, 5'h00, k + 1);
            pair(16'h1320 | 16'(k << 10), 5'h05, 5'h12, (k == 0) ? 0 : k + 1);
        end
        pair(16'h1320, 5'h02, 5'h15, 4);
        ahb(1'b0, 32'h4, 32'h0, rd);
        compare(rd, 32'h0000_0500);
        $display("test_counts done");
    endtask
    task automatic test_reset();
        logic [31:0] rd;
        int n;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        ahb(1'b0, 32'h0, 32'h0, rd);
        compare(rd, 32'h0000_FF00);
        cyc(5'h00, n);
        compare(n, 0);
        cyc(5'h10, n);
        compare(n, 4);
        $display("test_reset done");
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        test_regs();
        test_conditions();
        test_counts();
        test_reset();
        complete_run();
    end
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n > 5000) begin
            err_total++;
            complete_run();
        end
    end
endmodule
